// ===== include/trig_defines.svh
// timing constants for the pattern trigger timing block
// assumes a 50 MHz sys_clk; every timing figure here is in the unit named by the macro
`ifndef TRIG_DEFINES_SVH
`define TRIG_DEFINES_SVH

`define CLK_PERIOD_NS 20
`define CLK_PERIOD_PS 20000
// one delay step of the trigger controls
`define STEP_PS 107136
// earliest edge before exposure start, and latest edges after it
`define LEAD_NS 20050
`define OUT1_AFTER_NS 2790
`define OUT2_AFTER_NS 7290
// steps are rounded down so the programmed range never overshoots
`define LEAD_STEPS ((`LEAD_NS * 1000) / `STEP_PS)
`define OUT1_AFTER_STEPS ((`OUT1_AFTER_NS * 1000) / `STEP_PS)
`define OUT2_AFTER_STEPS ((`OUT2_AFTER_NS * 1000) / `STEP_PS)
// micromirror array load time between exposures
`define LOAD_GAP_US 230
`define US_CYCLES (1000 / `CLK_PERIOD_NS)
`define MS_CYCLES_DEF (1000000 / `CLK_PERIOD_NS)
// table depth and widths
`define PAT_DEPTH 64
`define IDX_W 6
`define TIME_W 24
`define IMG_W 5
`define DLY_W 18
`define OFF_W 9

`endif

// ===== include/trig_pkg.sv
// types shared by the pattern trigger timing block
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package trig_pkg;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_NEXT = 3'h1,
		S_LOAD = 3'h2,
		S_ARM = 3'h3,
		S_EXPOSE = 3'h4,
		S_GAP = 3'h5,
		S_TIMING = 3'h6
	} seq_state_e;

endpackage

`default_nettype wire

// ===== core/edge_delay.sv
// one-shot delay line counted in 107.136 ns steps
// assumes step_tick is a one-cycle pulse from the step generator
`default_nettype none
`include "trig_defines.svh"

module edge_delay (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic step_tick,
	input wire logic fire,
	input wire logic [`DLY_W-1:0] delay_steps,
	output logic done
);

	logic [`DLY_W-1:0] count_reg;
	logic busy_reg;

	// one event in flight; a new fire restarts the count (callers space events widely)
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			count_reg <= 18'h00000;
			busy_reg <= 1'b0;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (fire) begin
				if (delay_steps == 18'h00000) begin
					done <= 1'b1;
					busy_reg <= 1'b0;
				end else begin
					count_reg <= delay_steps;
					busy_reg <= 1'b1;
				end
			end else if (busy_reg && step_tick) begin
				if (count_reg == 18'h00001) begin
					done <= 1'b1;
					busy_reg <= 1'b0;
				end
				count_reg <= count_reg - 18'h00001;
			end
		end
	end

endmodule

`default_nettype wire

// ===== core/pattern_trigger_timing.sv
// pattern sequencer with trigger input delay and two programmable trigger outputs
// assumes synchronous inputs, a flash loader answering flash_req with a done pulse
//
// Overview of operation
// (R01) Trigger input rising edge is delayed by a count of 107.136 ns steps.
// (R02) Output 1 rises at exposure start plus a signed step offset, -20.05 to +2.79 us.
// (R03) Output 1 falls at exposure end plus a signed step offset, -20.05 to +2.79 us.
// (R04) Output 1 polarity: cleared is active high, set is active low.
// (R05) Output 2 rises at exposure start plus a signed step offset, -20.05 to +7.29 us.
// (R06) Output 2 polarity: cleared is active high, set is active low.
// (R07) Output 2 pulses once for every patterns-per-pulse displayed patterns.
// (R08) Output 1 brackets each pattern's exposure interval.
// (R09) Output 2 pulses at sequence start and on each 24-plane buffer change.
// (R10) Two 24-plane buffers; a missing image is reloaded from flash first.
// (R11) Variable exposure mode uses per-pattern exposure and period values.
// (R12) Load-timing request reloads the display buffer and reports milliseconds taken.
// (R13) Period must exceed exposure by 230 us for the array load.
// (R14) Untriggered patterns follow at once; triggered ones wait for their trigger.
// (R15) Play-once shows the first patterns-per-pulse patterns then stops; repeat loops.
// (R16) Delays and polarities reset to zero and active high, applied per pattern.
`default_nettype none
`include "trig_defines.svh"

module pattern_trigger_timing
	import trig_pkg::*;
#(
	parameter int MS_CYCLES = `MS_CYCLES_DEF
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic trig_in,
	input wire logic seq_start,
	input wire logic seq_stop,
	input wire logic play_once,
	input wire logic var_exposure,
	input wire logic [`IDX_W-1:0] seq_len,
	input wire logic [`TIME_W-1:0] global_exposure_us,
	input wire logic [`TIME_W-1:0] global_period_us,
	input wire logic [`DLY_W-1:0] trig_in_delay,
	input wire logic [`OFF_W-1:0] out1_rise_off,
	input wire logic [`OFF_W-1:0] out1_fall_off,
	input wire logic out1_invert,
	input wire logic [`OFF_W-1:0] out2_rise_off,
	input wire logic out2_invert,
	input wire logic [7:0] out2_per_pulse,
	input wire logic pat_wr_en,
	input wire logic [`IDX_W-1:0] pat_wr_idx,
	input wire logic pat_wr_untrig,
	input wire logic [`IMG_W-1:0] pat_wr_img,
	input wire logic [`TIME_W-1:0] pat_wr_exposure_us,
	input wire logic [`TIME_W-1:0] pat_wr_period_us,
	input wire logic flash_done,
	input wire logic timing_req,
	input wire logic [`IMG_W-1:0] timing_img,
	output logic trig_out1,
	output logic trig_out2,
	output logic array_expose,
	output logic flash_req,
	output logic [`IMG_W-1:0] flash_img,
	output logic flash_buf,
	output logic seq_running,
	output logic period_err,
	output logic [15:0] timing_ms,
	output logic timing_valid
);

	localparam int NCH = 5;

	seq_state_e state_reg;
	logic [16:0] step_acc_reg;
	logic step_tick_reg;
	logic [5:0] us_div_reg;
	logic us_tick_reg;
	logic trig_in_q_reg;
	logic trig_fire;
	logic [`IDX_W-1:0] idx_reg;
	logic [7:0] ppp_cnt_reg;
	logic [7:0] done_cnt_reg;
	logic [`TIME_W:0] us_cnt_reg;
	logic [`TIME_W:0] expo_len_reg;
	logic [`TIME_W:0] per_len_reg;
	logic first_reg;
	logic cur_buf_reg;
	logic pend_buf_reg;
	logic [`IMG_W-1:0] buf_img_reg [2];
	logic [1:0] buf_valid_reg;
	logic fire_start_reg;
	logic fire_end_reg;
	logic marker_reg;
	logic [`OFF_W-1:0] r1_sh_reg;
	logic [`OFF_W-1:0] f1_sh_reg;
	logic [`OFF_W-1:0] r2_sh_reg;
	logic inv1_sh_reg;
	logic inv2_sh_reg;
	logic [15:0] ms_div_reg;
	logic [15:0] ms_cnt_reg;
	logic lvl1_reg;
	logic lvl2_reg;
	logic expo_lvl_reg;
	logic [NCH-1:0] ch_fire;
	logic [NCH-1:0] ch_done;
	logic [`DLY_W-1:0] ch_delay [NCH];

	// pattern table
	logic pat_untrig [`PAT_DEPTH];
	logic [`IMG_W-1:0] pat_img [`PAT_DEPTH];
	logic [`TIME_W-1:0] pat_expo [`PAT_DEPTH];
	logic [`TIME_W-1:0] pat_per [`PAT_DEPTH];

	logic [`TIME_W-1:0] expo_sel;
	logic [`TIME_W-1:0] per_sel;
	logic [`TIME_W:0] expo_min;
	logic [`TIME_W:0] per_need;
	logic [`IMG_W-1:0] img_sel;
	logic hit0;
	logic hit1;
	logic [7:0] ppp_eff;
	logic [7:0] ppp_inc;
	logic arm_go;

	always_ff @(posedge sys_clk) begin
		if (pat_wr_en) begin
			pat_untrig[pat_wr_idx] <= pat_wr_untrig;
			pat_img[pat_wr_idx] <= pat_wr_img;
			pat_expo[pat_wr_idx] <= pat_wr_exposure_us;
			pat_per[pat_wr_idx] <= pat_wr_period_us;
		end
	end

	assign expo_sel = var_exposure ? pat_expo[idx_reg] : global_exposure_us; // R11
	assign per_sel = var_exposure ? pat_per[idx_reg] : global_period_us; // R11
	assign img_sel = pat_img[idx_reg];
	assign expo_min = (expo_sel == 24'h000000) ? 25'h0000001 : {1'b0, expo_sel};
	assign per_need = expo_min + 25'(`LOAD_GAP_US);
	assign hit0 = buf_valid_reg[0] && (buf_img_reg[0] == img_sel);
	assign hit1 = buf_valid_reg[1] && (buf_img_reg[1] == img_sel);
	assign ppp_eff = (out2_per_pulse == 8'h00) ? 8'h01 : out2_per_pulse;
	assign ppp_inc = ppp_cnt_reg + 8'h01;
	assign arm_go = (state_reg == S_ARM) && (pat_untrig[idx_reg] || trig_fire);

	// signed offset to a non-negative delay: everything is scheduled one lead ahead
	function automatic logic [`DLY_W-1:0] edge_steps(input logic [`OFF_W-1:0] off,
		input logic [10:0] after);
		logic signed [10:0] t;
		t = $signed(11'(`LEAD_STEPS)) + $signed({{2{off[`OFF_W-1]}}, off});
		if (t < 0) begin
			t = 11'sh000;
		end else if (t > $signed(11'(`LEAD_STEPS) + after)) begin
			t = $signed(11'(`LEAD_STEPS) + after);
		end
		edge_steps = `DLY_W'(unsigned'(t));
	endfunction

	// 107.136 ns step from a picosecond accumulator; jitter is under one clock
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			step_acc_reg <= 17'h00000;
			step_tick_reg <= 1'b0;
		end else if (step_acc_reg + 17'(`CLK_PERIOD_PS) >= 17'(`STEP_PS)) begin
			step_acc_reg <= step_acc_reg + 17'(`CLK_PERIOD_PS) - 17'(`STEP_PS);
			step_tick_reg <= 1'b1;
		end else begin
			step_acc_reg <= step_acc_reg + 17'(`CLK_PERIOD_PS);
			step_tick_reg <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			us_div_reg <= 6'h00;
			us_tick_reg <= 1'b0;
		end else if (arm_go) begin
			// restart the grid at each pattern start: the first counted tick lands
			// exactly one microsecond later, so exposure and period are never cut short
			us_div_reg <= 6'h01; // R08
			us_tick_reg <= 1'b0;
		end else begin
			us_tick_reg <= (us_div_reg == 6'(`US_CYCLES - 1));
			us_div_reg <= (us_div_reg == 6'(`US_CYCLES - 1)) ? 6'h00 : us_div_reg + 6'h01;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_in_q_reg <= 1'b0;
		end else begin
			trig_in_q_reg <= trig_in;
		end
	end

	edge_delay u_trig_in_delay (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.step_tick(step_tick_reg),
		.fire(trig_in && !trig_in_q_reg), // R01
		.delay_steps(trig_in_delay), // R01
		.done(trig_fire)
	);

	assign ch_fire = {fire_start_reg && marker_reg, fire_end_reg, fire_start_reg, fire_end_reg,
		fire_start_reg};
	assign ch_delay[0] = `DLY_W'(`LEAD_STEPS);
	assign ch_delay[1] = `DLY_W'(`LEAD_STEPS);
	assign ch_delay[2] = edge_steps(r1_sh_reg, 11'(`OUT1_AFTER_STEPS)); // R02
	assign ch_delay[3] = edge_steps(f1_sh_reg, 11'(`OUT1_AFTER_STEPS)); // R03
	assign ch_delay[4] = edge_steps(r2_sh_reg, 11'(`OUT2_AFTER_STEPS)); // R05

	// channels: exposure on, exposure off, out1 rise, out1 fall, out2 rise
	for (genvar c = 0; c < NCH; c++) begin : g_edge
		edge_delay u_edge (
			.sys_clk(sys_clk),
			.rst_n(rst_n),
			.step_tick(step_tick_reg),
			.fire(ch_fire[c]),
			.delay_steps(ch_delay[c]),
			.done(ch_done[c])
		);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= S_IDLE;
			idx_reg <= 6'h00;
			ppp_cnt_reg <= 8'h00;
			done_cnt_reg <= 8'h00;
			us_cnt_reg <= 25'h0000000;
			expo_len_reg <= 25'h0000001;
			per_len_reg <= 25'h0000001;
			first_reg <= 1'b1;
			cur_buf_reg <= 1'b0;
			pend_buf_reg <= 1'b0;
			buf_img_reg[0] <= 5'h00;
			buf_img_reg[1] <= 5'h00;
			buf_valid_reg <= 2'h0;
			fire_start_reg <= 1'b0;
			fire_end_reg <= 1'b0;
			marker_reg <= 1'b0;
			r1_sh_reg <= 9'h000; // R16
			f1_sh_reg <= 9'h000; // R16
			r2_sh_reg <= 9'h000; // R16
			inv1_sh_reg <= 1'b0; // R16
			inv2_sh_reg <= 1'b0; // R16
			flash_req <= 1'b0;
			flash_img <= 5'h00;
			flash_buf <= 1'b0;
			period_err <= 1'b0;
			timing_ms <= 16'h0000;
			timing_valid <= 1'b0;
		end else begin
			fire_start_reg <= 1'b0;
			fire_end_reg <= 1'b0;
			timing_valid <= 1'b0;
			if (seq_stop && state_reg != S_TIMING) begin
				state_reg <= S_IDLE;
				flash_req <= 1'b0;
			end else begin
				unique case (state_reg)
					S_IDLE: begin
						if (seq_start) begin
							idx_reg <= 6'h00;
							ppp_cnt_reg <= 8'h00;
							done_cnt_reg <= 8'h00;
							first_reg <= 1'b1;
							period_err <= 1'b0;
							state_reg <= S_NEXT;
						end else if (timing_req) begin
							flash_req <= 1'b1; // R12
							flash_img <= timing_img;
							flash_buf <= cur_buf_reg;
							buf_valid_reg[cur_buf_reg] <= 1'b0; // R12
							state_reg <= S_TIMING;
						end
					end
					S_NEXT: begin
						if (hit0 || hit1) begin
							pend_buf_reg <= !hit0;
							state_reg <= S_ARM;
						end else begin
							// reload into the buffer not on display so it keeps playing
							flash_req <= 1'b1; // R10
							flash_img <= img_sel;
							flash_buf <= !cur_buf_reg;
							buf_valid_reg[!cur_buf_reg] <= 1'b0;
							state_reg <= S_LOAD;
						end
					end
					S_LOAD: begin
						if (flash_done) begin
							flash_req <= 1'b0;
							buf_img_reg[flash_buf] <= flash_img; // R10
							buf_valid_reg[flash_buf] <= 1'b1;
							pend_buf_reg <= flash_buf;
							state_reg <= S_ARM;
						end
					end
					S_ARM: begin
						// a trigger that lands before this state is not remembered
						if (pat_untrig[idx_reg] || trig_fire) begin // R14
							r1_sh_reg <= out1_rise_off; // R16
							f1_sh_reg <= out1_fall_off; // R16
							r2_sh_reg <= out2_rise_off; // R16
							inv1_sh_reg <= out1_invert; // R16
							inv2_sh_reg <= out2_invert; // R16
							expo_len_reg <= expo_min;
							// too short a period is stretched so the array can load
							per_len_reg <= ({1'b0, per_sel} < per_need) ? per_need
								: {1'b0, per_sel}; // R13
							if ({1'b0, per_sel} < per_need) begin
								period_err <= 1'b1; // R13
							end
							fire_start_reg <= 1'b1; // R08
							if (first_reg || pend_buf_reg != cur_buf_reg) begin
								marker_reg <= 1'b1; // R09
								ppp_cnt_reg <= (ppp_eff == 8'h01) ? 8'h00 : 8'h01;
							end else begin
								marker_reg <= (ppp_cnt_reg == 8'h00); // R07
								ppp_cnt_reg <= (ppp_inc >= ppp_eff) ? 8'h00 : ppp_inc; // R07
							end
							cur_buf_reg <= pend_buf_reg;
							first_reg <= 1'b0;
							us_cnt_reg <= 25'h0000000;
							state_reg <= S_EXPOSE;
						end
					end
					S_EXPOSE: begin
						if (us_tick_reg) begin
							us_cnt_reg <= us_cnt_reg + 25'h0000001;
							if (us_cnt_reg + 25'h0000001 >= expo_len_reg) begin
								fire_end_reg <= 1'b1; // R08
								state_reg <= S_GAP;
							end
						end
					end
					S_GAP: begin
						if (us_tick_reg) begin
							us_cnt_reg <= us_cnt_reg + 25'h0000001;
							if (us_cnt_reg + 25'h0000001 >= per_len_reg) begin
								done_cnt_reg <= done_cnt_reg + 8'h01;
								if (play_once && done_cnt_reg + 8'h01 >= ppp_eff) begin
									state_reg <= S_IDLE; // R15
								end else begin
									idx_reg <= (idx_reg + 6'h01 >= seq_len) ? 6'h00
										: idx_reg + 6'h01; // R15
									state_reg <= S_NEXT;
								end
							end
						end
					end
					S_TIMING: begin
						if (flash_done) begin
							flash_req <= 1'b0;
							buf_img_reg[flash_buf] <= flash_img;
							buf_valid_reg[flash_buf] <= 1'b1;
							timing_ms <= ms_cnt_reg; // R12
							timing_valid <= 1'b1; // R12
							state_reg <= S_IDLE;
						end
					end
					default: begin
						state_reg <= S_IDLE;
					end
				endcase
			end
		end
	end

	// elapsed milliseconds of a load-timing request, saturating
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ms_div_reg <= 16'h0000;
			ms_cnt_reg <= 16'h0000;
		end else if (state_reg != S_TIMING) begin
			ms_div_reg <= 16'h0000;
			ms_cnt_reg <= 16'h0000;
		end else if (ms_div_reg == 16'(MS_CYCLES - 1)) begin
			ms_div_reg <= 16'h0000;
			if (ms_cnt_reg != 16'hFFFF) begin
				ms_cnt_reg <= ms_cnt_reg + 16'h0001; // R12
			end
		end else begin
			ms_div_reg <= ms_div_reg + 16'h0001;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			lvl1_reg <= 1'b0;
			lvl2_reg <= 1'b0;
			expo_lvl_reg <= 1'b0;
		end else begin
			if (ch_done[2]) begin
				lvl1_reg <= 1'b1; // R02
			end else if (ch_done[3]) begin
				lvl1_reg <= 1'b0; // R03
			end
			// output 2 ends with output 1 so its width follows the exposure
			if (ch_done[4]) begin
				lvl2_reg <= 1'b1; // R05
			end else if (ch_done[3]) begin
				lvl2_reg <= 1'b0; // R09
			end
			if (ch_done[0]) begin
				expo_lvl_reg <= 1'b1;
			end else if (ch_done[1]) begin
				expo_lvl_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			trig_out1 <= 1'b0;
			trig_out2 <= 1'b0;
			array_expose <= 1'b0;
			seq_running <= 1'b0;
		end else begin
			trig_out1 <= lvl1_reg ^ inv1_sh_reg; // R04
			trig_out2 <= lvl2_reg ^ inv2_sh_reg; // R06
			array_expose <= expo_lvl_reg;
			seq_running <= (state_reg != S_IDLE) && (state_reg != S_TIMING);
		end
	end

endmodule

`default_nettype wire

// ===== bench/trig_source_model.sv
// trigger source and flash loader standing outside the pattern trigger timing block
// assumes fire is a one-cycle request from the bench and flash_lat counts cycles per load
`default_nettype none

module trig_source_model
	import trig_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic flash_req,
	input wire logic fire,
	input wire logic [15:0] flash_lat,
	output logic trig_in,
	output logic flash_done
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] wait_reg;
	logic [3:0] hi_reg;

	// the camera drives its trigger line low between pulses, never floats it
	assign trig_in = (hi_reg != 4'h0);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			hi_reg <= 4'h0;
		end else if (fire) begin
			hi_reg <= 4'hA;
		end else if (hi_reg != 4'h0) begin
			hi_reg <= hi_reg - 4'h1;
		end
	end

	// one done pulse per load; the count restarts once the request drops
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			wait_reg <= 16'h0;
			flash_done <= 1'h0;
		end else if (!flash_req || flash_done) begin
			wait_reg <= 16'h0;
			flash_done <= 1'h0;
		end else begin
			wait_reg <= wait_reg + 16'h1;
			flash_done <= (wait_reg == flash_lat);
		end
	end
endmodule

`default_nettype wire

// ===== bench/trig_timing_properties.sv
// port-level assertions for the pattern trigger timing block
// assumes a single sys_clk domain with rst_n asynchronous active low
`default_nettype none
`include "trig_defines.svh"

module trig_timing_checker
	import trig_pkg::*;
#(
	parameter int MS_CYCLES = 50000
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic seq_start,
	input wire logic timing_req,
	input wire logic [`IMG_W-1:0] timing_img,
	input wire logic flash_done,
	input wire logic trig_out1,
	input wire logic trig_out2,
	input wire logic array_expose,
	input wire logic flash_req,
	input wire logic [`IMG_W-1:0] flash_img,
	input wire logic flash_buf,
	input wire logic seq_running,
	input wire logic period_err,
	input wire logic [15:0] timing_ms,
	input wire logic timing_valid
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	chk_reset_quiet:
	assert property ($rose(rst_n) |-> !trig_out1 && !trig_out2 && !flash_req && !seq_running)
		else $error("outputs not quiet after reset");
	chk_start_runs:
	assert property (seq_start && !seq_running && !flash_req |-> ##2 seq_running)
		else $error("sequence did not start two cycles after request");
	chk_err_clear:
	assert property (seq_start && !seq_running && !flash_req |=> !period_err)
		else $error("period error not cleared by start");
	chk_flash_hold:
	assert property (flash_req && !flash_done |=>
		flash_req && $stable(flash_img) && $stable(flash_buf))
		else $error("flash request changed before done");
	chk_flash_drop:
	assert property (flash_req && flash_done |=> !flash_req)
		else $error("flash request held after done");
	chk_timing_load:
	assert property (timing_req && !seq_running && !flash_req && !seq_start |=>
		flash_req && flash_img == $past(timing_img))
		else $error("load timing request not taken");
	chk_valid_cause:
	assert property (timing_valid |-> $past(flash_done) ##1 !timing_valid)
		else $error("timing result without a finished load");
	chk_ms_update:
	assert property ($changed(timing_ms) |-> timing_valid)
		else $error("timing result changed without valid");
	chk_expose_min:
	assert property ($rose(array_expose) |-> array_expose [*8])
		else $error("exposure window shorter than minimum");
endmodule

bind pattern_trigger_timing trig_timing_checker #(.MS_CYCLES(MS_CYCLES)) chk_u (
	.sys_clk, .rst_n, .seq_start, .timing_req, .timing_img, .flash_done, .trig_out1,
	.trig_out2, .array_expose, .flash_req, .flash_img, .flash_buf, .seq_running,
	.period_err, .timing_ms, .timing_valid
);

`default_nettype wire

// ===== bench/tb_top.sv
// self-checking bench for the pattern trigger timing block
// assumes the trigger source model answers flash loads and fires triggers on request
`default_nettype none
`include "trig_defines.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
	$display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAIT(c, n) for (int k = 0; k < (n) && !(c); k++) begin @(posedge sys_clk); #2; end \
	`CHK(1'(c), 1'h1)

module tb_top
	import trig_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk = 1'h0, rst_n = 1'h0, seq_start = 1'h0, seq_stop = 1'h0, fire = 1'h0;
	logic play_once = 1'h1, var_exposure = 1'h0, out1_invert = 1'h0, out2_invert = 1'h0;
	logic [`IDX_W-1:0] seq_len = 6'h1, pat_wr_idx = 6'h0;
	logic [`TIME_W-1:0] global_exposure_us = 24'hA, global_period_us = 24'h0;
	logic [`TIME_W-1:0] pat_wr_exposure_us = 24'h0, pat_wr_period_us = 24'h0;
	logic [`DLY_W-1:0] trig_in_delay = 18'h0;
	logic [`OFF_W-1:0] out1_rise_off = 9'h0, out1_fall_off = 9'h0, out2_rise_off = 9'h0;
	logic [7:0] out2_per_pulse = 8'h1;
	logic pat_wr_en = 1'h0, pat_wr_untrig = 1'h0, timing_req = 1'h0;
	logic [`IMG_W-1:0] pat_wr_img = 5'h0, timing_img = 5'h0, flash_img;
	logic [15:0] flash_lat = 16'h14, timing_ms;
	logic trig_in, flash_done, trig_out1, trig_out2, array_expose, flash_req, flash_buf;
	logic seq_running, period_err, timing_valid, p1, p2, pa, pt;
	int num_errors = 0, n_tests = 0, cyc = 0, n1, n2, na, r1, f1, r2, fa, rt;
	int ra_t[4];

	pattern_trigger_timing #(.MS_CYCLES(50)) dut_u (.sys_clk, .rst_n, .trig_in, .seq_start,
		.seq_stop, .play_once, .var_exposure, .seq_len, .global_exposure_us,
		.global_period_us, .trig_in_delay, .out1_rise_off, .out1_fall_off, .out1_invert,
		.out2_rise_off, .out2_invert, .out2_per_pulse, .pat_wr_en, .pat_wr_idx,
		.pat_wr_untrig, .pat_wr_img, .pat_wr_exposure_us, .pat_wr_period_us, .flash_done,
		.timing_req, .timing_img, .trig_out1, .trig_out2, .array_expose, .flash_req,
		.flash_img, .flash_buf, .seq_running, .period_err, .timing_ms, .timing_valid);
	trig_source_model src_u (.sys_clk, .rst_n, .flash_req, .fire, .flash_lat, .trig_in,
		.flash_done);

	always #10 sys_clk = ~sys_clk;

	// edge stamps in cycles; cyc updates by nonblocking so every stamp sees one value
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		{p1, p2, pa, pt} <= {trig_out1, trig_out2, array_expose, trig_in};
		if (trig_out1 && !p1) begin
			r1 <= cyc;
			n1 <= n1 + 1;
		end
		if (!trig_out1 && p1) f1 <= cyc;
		if (trig_out2 && !p2) begin
			r2 <= cyc;
			n2 <= n2 + 1;
		end
		if (array_expose && !pa) begin
			ra_t[na] <= cyc;
			na <= na + 1;
		end
		if (!array_expose && pa) fa <= cyc;
		if (trig_in && !pt) rt <= cyc;
		if (cyc == 100000) begin
			num_errors++;
			wrap_up();
		end
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#2;
	endtask

	task automatic wr_pat(input logic [5:0] idx, input logic untrig, input logic [4:0] img,
		input logic [23:0] ex, input logic [23:0] per);
		{pat_wr_en, pat_wr_idx, pat_wr_untrig, pat_wr_img} = {1'h1, idx, untrig, img};
		{pat_wr_exposure_us, pat_wr_period_us} = {ex, per};
		tick(1);
		// enable is left up for back-to-back writes; the caller lowers it
	endtask

	task automatic start_seq();
		seq_start = 1'h1;
		tick(1);
		seq_start = 1'h0;
		{n1, n2, na} = '0;
	endtask

	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	initial begin
		tick(2);
		`CHK({trig_out1, trig_out2, flash_req, seq_running}, 4'h0)
		rst_n = 1'h1;
		tick(1);
		`CHK({trig_out1, trig_out2, flash_req, seq_running}, 4'h0)
		// 50-cycle milliseconds: about 3.5 and 1.2 of them elapse per load
		for (int i = 0; i < 2; i++) begin
			flash_lat = i ? 16'h3C : 16'hAF;
			timing_img = 5'h7;
			timing_req = 1'h1;
			tick(1);
			timing_req = 1'h0;
			`CHK(flash_req, 1'h1)
			`WAIT(timing_valid, 400)
			`CHK(timing_ms, i ? 16'h1 : 16'h3)
		end
		flash_lat = 16'h14;
		wr_pat(6'h0, 1'h1, 5'h2, 24'h0, 24'h0);
		wr_pat(6'h1, 1'h1, 5'h2, 24'h0, 24'h0);
		wr_pat(6'h2, 1'h1, 5'h3, 24'h0, 24'h0);
		pat_wr_en = 1'h0;
		{seq_len, out2_per_pulse} = {6'h3, 8'h3};
		{out1_rise_off, out1_fall_off, out2_rise_off} = {9'h1F6, 9'h005, 9'h014};
		start_seq();
		`WAIT(flash_req, 10)
		`CHK(flash_img, 5'h2)
		`CHK(flash_buf, 1'h1)
		`WAIT(!seq_running, 45000)
		tick(2000);
		`CHK(n1, 3)
		`CHK(n2, 2)
		`CHK(period_err, 1'h1)
		`CHK(ra_t[1] - ra_t[0] inside {[11990:12012]}, 1'h1)
		`CHK(ra_t[2] - r1 inside {[40:66]}, 1'h1)
		`CHK(f1 - fa inside {[15:40]}, 1'h1)
		`CHK(r2 - ra_t[2] inside {[95:120]}, 1'h1)
		`CHK(fa - ra_t[2] inside {[490:512]}, 1'h1)
		// one triggered pattern with its own 20 us exposure, both outputs inverted
		wr_pat(6'h0, 1'h0, 5'h2, 24'h14, 24'h12C);
		pat_wr_en = 1'h0;
		{seq_len, out2_per_pulse} = {6'h1, 8'h1};
		{var_exposure, out1_invert, out2_invert} = 3'h7;
		{out1_rise_off, out1_fall_off, trig_in_delay} = {9'h0, 9'h0, 18'h64};
		start_seq();
		tick(300);
		`CHK(array_expose, 1'h0)
		fire = 1'h1;
		tick(1);
		fire = 1'h0;
		`WAIT(array_expose, 2000)
		tick(500);
		`CHK({trig_out1, trig_out2}, 2'h0)
		`WAIT(!seq_running, 20000)
		tick(2000);
		`CHK({trig_out1, trig_out2}, 2'h3)
		`CHK(ra_t[0] - rt inside {[1530:1555]}, 1'h1)
		`CHK(r1 - f1 inside {[990:1012]}, 1'h1)
		`CHK(period_err, 1'h0)
		// repeat mode: one untriggered 1 us pattern loops until stopped
		wr_pat(6'h0, 1'h1, 5'h2, 24'h1, 24'h0);
		pat_wr_en = 1'h0;
		play_once = 1'h0;
		start_seq();
		tick(13000);
		`CHK(na, 2)
		`CHK(period_err, 1'h1)
		seq_stop = 1'h1;
		tick(1);
		seq_stop = 1'h0;
		tick(2);
		`CHK(seq_running, 1'h0)
		wrap_up();
	end
endmodule

`default_nettype wire
